// File: rtl/fbn_pkg.sv
// Package of constants and types for the fieldbus node framer
// Overview of operation
// - Two-channel input: data in bits 0-1, status in bits 2-3 of one byte.
// - Data plus status over eight bits: data byte first, status byte next.
// - Operator panel input words follow all module input bytes.
// - Global commands addressed to 127 accepted besides own station address.
// - Global commands ignored until cyclic data exchange has started.
// - Freeze latches newest inputs; master then reads that snapshot.
// - While frozen, scanning goes on; each freeze refreshes the snapshot.
// - Unfreeze ends frozen mode; live inputs return to the master.
// - Clear data command empties the output data buffer.
// - Node builds its own diagnostics message with status and fault location.
// - Default diagnostics: 32 bytes, 6 standard, 9 island, 17 module.
// - Bytes 0-2 station status, 3 master address, 4-5 ident high/low.
// - Byte 6 header 09h; bytes 7-8 firmware release low then high.
// - Bytes 9/14 device status, 10-11 island state, 12-13 global errors.
// - Default layout: byte 15 header 51h.
// - Bytes 16-19 one health bit per module, 1 means not healthy.
// - Default layout: bytes 20-31 reserved, sent as zero.
// - Extended format grows message up to 62 bytes, 42 for channels.
// - Extended: byte 15 header 45h, channel records from byte 20.
// - Three bytes per channel, at most 14 channels, length 20 to 62.
// - Status byte 0: bit 3 diagnostics present, bit 1 not ready, bit 2 fault.
package fbn_pkg;
  localparam logic [6:0] GC_ADDR = 7'h7F;
  localparam int IMG_BYTES = 32;
  localparam int PAN_BYTES = 4;
  localparam int OD_BYTES = 16;
  localparam int CH_MAX = 14;
  localparam logic [4:0] PACK_BITS = 5'h08;
  localparam logic [5:0] DIAG_DEF_LEN = 6'h20;
  localparam logic [5:0] DIAG_EXT_BASE = 6'h14;
  localparam logic [7:0] HDR_ISLAND = 8'h09;
  localparam logic [7:0] HDR_MOD_DEF = 8'h51;
  localparam logic [7:0] HDR_MOD_EXT = 8'h45;
  localparam int SS1_NOT_READY = 1;
  localparam int SS1_CFG_FAULT = 2;
  localparam int SS1_DIAG = 3;
  // Arbitrary neutral identification value
  localparam logic [15:0] IDENT_CODE = 16'h0A5C;

  typedef enum logic [1:0] {GC_NONE, GC_FREEZE, GC_UNFREEZE, GC_CLEAR}
    fbn_gc_t;
  typedef enum logic [1:0] {TX_IDLE, TX_IN, TX_DIAG} fbn_tx_t;

  typedef struct packed {
    logic panel;
    logic last;
    logic [15:0] data;
    logic [3:0] dbits;
    logic [7:0] status;
    logic [3:0] sbits;
  } fbn_rec_t;

  typedef struct packed {
    logic [7:0] stat2;
    logic [7:0] stat3;
    logic [7:0] master_addr;
    logic [15:0] fw_rev;
    logic [15:0] node_health_word;
    logic [15:0] island_state;
    logic [15:0] global_err;
    logic not_ready;
    logic cfg_fault;
  } fbn_diag_t;

  typedef struct packed {
    logic [7:0] data;
    logic last;
    logic diag;
  } fbn_byte_t;

  typedef struct packed {
    logic [IMG_BYTES-1:0][7:0] mb;
    logic [5:0] mlen;
    logic [PAN_BYTES-1:0][7:0] pb;
    logic [2:0] plen;
    logic [5:0] wp;
    logic [2:0] pp;
  } fbn_img_t;

  typedef struct packed {
    fbn_img_t live;
    fbn_img_t snap;
    logic frozen;
    logic dx_started;
    logic [OD_BYTES-1:0][7:0] od;
    logic [31:0] health;
    fbn_tx_t tx;
    logic [5:0] idx;
    logic [5:0] len;
    logic [3:0] ch_i;
    logic [1:0] ch_b;
    logic hd_v;
    fbn_byte_t hd;
    logic tl_v;
    fbn_byte_t tl;
  } fbn_state_t;
endpackage

// File: rtl/fbn_framer.sv
// Input packing, global commands and diagnostics framing of the node
`timescale 1ns/100ps
module fbn_framer
  import fbn_pkg::*;
(
  input wire logic sys_clk,
  input wire logic rstn,
  input wire logic [6:0] station_addr,
  input wire logic rec_valid,
  input wire fbn_rec_t rec,
  input wire logic health_valid,
  input wire logic [31:0] health_in,
  input wire logic gc_valid,
  input wire logic [6:0] gc_addr,
  input wire fbn_gc_t gc_cmd,
  input wire logic od_wr,
  input wire logic [3:0] od_idx,
  input wire logic [7:0] od_byte,
  input wire logic in_req,
  input wire logic diag_req,
  input wire logic diag_ext,
  input wire logic [3:0] ch_count,
  input wire logic [CH_MAX-1:0][23:0] ch_rec,
  input wire fbn_diag_t dinfo,
  input wire logic out_ready,
  output logic out_valid,
  output logic [7:0] out_data,
  output logic out_last,
  output logic out_diag,
  output logic frozen,
  output logic dx_started,
  output logic [OD_BYTES-1:0][7:0] out_image
);
  fbn_state_t s, n;
  logic push_v;
  fbn_byte_t push_b;
  logic gc_hit;
  logic [3:0] ch_cnt;
  logic diag_any;
  logic [7:0] diag_b;
  logic [7:0] pack_b;

  function automatic logic [7:0] lowbits(logic [7:0] v, logic [3:0] w);
    logic [15:0] m;
    m = (16'h0001 << w) - 16'h0001;
    return v & m[7:0];
  endfunction

  assign ch_cnt = (ch_count > 4'(CH_MAX)) ? 4'(CH_MAX) : ch_count;
  assign diag_any = (|s.health) | (diag_ext & (ch_cnt != 4'h0));
  assign gc_hit = gc_valid && s.dx_started &&
    (gc_addr == GC_ADDR || gc_addr == station_addr);
  // Data bits low, status shifted above them
  assign pack_b = lowbits(rec.data[7:0], rec.dbits) |
    8'({8'h00, lowbits(rec.status, rec.sbits)} << rec.dbits);

  always_comb begin
    diag_b = 8'h00;
    unique case (s.idx)
      6'h00: diag_b = {4'h0, diag_any, dinfo.cfg_fault,
                       dinfo.not_ready, 1'b0};
      6'h01: diag_b = dinfo.stat2;
      6'h02: diag_b = dinfo.stat3;
      6'h03: diag_b = dinfo.master_addr;
      6'h04: diag_b = IDENT_CODE[15:8];
      6'h05: diag_b = IDENT_CODE[7:0];
      6'h06: diag_b = HDR_ISLAND;
      6'h07: diag_b = dinfo.fw_rev[7:0];
      6'h08: diag_b = dinfo.fw_rev[15:8];
      6'h09: diag_b = dinfo.node_health_word[7:0];
      6'h0A: diag_b = dinfo.island_state[7:0];
      6'h0B: diag_b = dinfo.island_state[15:8];
      6'h0C: diag_b = dinfo.global_err[7:0];
      6'h0D: diag_b = dinfo.global_err[15:8];
      6'h0E: diag_b = dinfo.node_health_word[15:8];
      6'h0F: diag_b = diag_ext ? HDR_MOD_EXT : HDR_MOD_DEF;
      6'h10: diag_b = s.health[7:0];
      6'h11: diag_b = s.health[15:8];
      6'h12: diag_b = s.health[23:16];
      6'h13: diag_b = s.health[31:24];
      default: begin
        // Reserved bytes stay zero in the default layout
        if (diag_ext) begin
          diag_b = ch_rec[s.ch_i][23 - 8 * s.ch_b -: 8];
        end
      end
    endcase
  end

  always_comb begin
    n = s;
    push_v = 1'b0;
    push_b = '0;
    // Island scan into the live image, frozen or not
    if (rec_valid) begin
      if (rec.panel) begin
        if (s.live.pp <= 3'(PAN_BYTES - 2)) begin
          n.live.pb[s.live.pp[1:0]] = rec.data[15:8];
          n.live.pb[s.live.pp[1:0] + 2'h1] = rec.data[7:0];
          n.live.pp = s.live.pp + 3'h2;
        end
      end else if ({1'b0, rec.dbits} + {1'b0, rec.sbits} <= PACK_BITS) begin
        if (s.live.wp < 6'(IMG_BYTES)) begin
          n.live.mb[s.live.wp[4:0]] = pack_b;
          n.live.wp = s.live.wp + 6'h01;
        end
      end else if (s.live.wp < 6'(IMG_BYTES - 1)) begin
        n.live.mb[s.live.wp[4:0]] = lowbits(rec.data[7:0], rec.dbits);
        n.live.mb[s.live.wp[4:0] + 5'h01] = lowbits(rec.status, rec.sbits);
        n.live.wp = s.live.wp + 6'h02;
      end
      if (rec.last) begin
        n.live.mlen = n.live.wp;
        n.live.plen = n.live.pp;
        n.live.wp = 6'h00;
        n.live.pp = 3'h0;
      end
    end
    if (health_valid) begin
      n.health = health_in;
    end
    if (od_wr) begin
      n.od[od_idx] = od_byte;
    end
    if (gc_hit) begin
      unique case (gc_cmd)
        GC_FREEZE: begin
          n.frozen = 1'b1;
          n.snap = n.live;
        end
        GC_UNFREEZE: n.frozen = 1'b0;
        GC_CLEAR: n.od = '0;
        GC_NONE: ;
      endcase
    end
    // Two-entry output buffer, pop first so a full head drains
    if (s.hd_v && out_ready) begin
      n.hd = s.tl;
      n.hd_v = s.tl_v;
      n.tl_v = 1'b0;
    end
    unique case (s.tx)
      TX_IDLE: begin
        n.idx = 6'h00;
        n.ch_i = 4'h0;
        n.ch_b = 2'h0;
        if (in_req) begin
          n.dx_started = 1'b1;
          n.len = s.frozen ? s.snap.mlen + 6'(s.snap.plen) :
            s.live.mlen + 6'(s.live.plen);
          n.tx = (n.len != 6'h00) ? TX_IN : TX_IDLE;
        end else if (diag_req) begin
          n.tx = TX_DIAG;
          n.len = diag_ext ? DIAG_EXT_BASE + 6'({ch_cnt, 1'b0}) +
            6'(ch_cnt) : DIAG_DEF_LEN;
        end
      end
      TX_IN: begin
        if (!s.tl_v) begin
          push_v = 1'b1;
          if (s.frozen) begin
            push_b.data = (s.idx < s.snap.mlen) ? s.snap.mb[s.idx[4:0]] :
              s.snap.pb[2'(s.idx - s.snap.mlen)];
          end else begin
            push_b.data = (s.idx < s.live.mlen) ? s.live.mb[s.idx[4:0]] :
              s.live.pb[2'(s.idx - s.live.mlen)];
          end
        end
      end
      TX_DIAG: begin
        if (!s.tl_v) begin
          push_v = 1'b1;
          push_b.data = diag_b;
          push_b.diag = 1'b1;
          if (s.idx >= DIAG_EXT_BASE) begin
            n.ch_b = (s.ch_b == 2'h2) ? 2'h0 : s.ch_b + 2'h1;
            n.ch_i = (s.ch_b == 2'h2) ? s.ch_i + 4'h1 : s.ch_i;
          end
        end
      end
      default: n.tx = TX_IDLE;
    endcase
    if (push_v) begin
      push_b.last = (s.idx == s.len - 6'h01);
      n.idx = s.idx + 6'h01;
      if (push_b.last) begin
        n.tx = TX_IDLE;
      end
      if (!n.hd_v) begin
        n.hd = push_b;
        n.hd_v = 1'b1;
      end else begin
        n.tl = push_b;
        n.tl_v = 1'b1;
      end
    end
  end

  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      s <= '0;
    end else begin
      s <= n;
    end
  end

  assign out_valid = s.hd_v;
  assign out_data = s.hd.data;
  assign out_last = s.hd.last;
  assign out_diag = s.hd.diag;
  assign frozen = s.frozen;
  assign dx_started = s.dx_started;
  assign out_image = s.od;

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rstn);

  a_gc_before_dx: assert property (
    gc_valid && !s.dx_started && !od_wr |=> $stable(s.frozen) &&
      $stable(s.od) && $stable(s.snap)
  ) else $error("Global command acted before data exchange");
  a_freeze_snap: assert property (
    gc_hit && gc_cmd == GC_FREEZE |=> s.frozen && s.snap.mb == s.live.mb
  ) else $error("Freeze did not latch inputs");
  a_snap_steady: assert property (
    s.frozen && !(gc_hit && gc_cmd == GC_FREEZE) |=> $stable(s.snap)
  ) else $error("Snapshot changed while frozen");
  a_unfreeze_live: assert property (
    gc_hit && gc_cmd == GC_UNFREEZE |=> !s.frozen
  ) else $error("Unfreeze did not end frozen mode");
  a_clear_empty: assert property (
    gc_hit && gc_cmd == GC_CLEAR |=> out_image == '0
  ) else $error("Clear data left output buffer");
  a_own_addr: assert property (
    gc_valid && s.dx_started && gc_addr != GC_ADDR &&
      gc_addr != station_addr |-> !gc_hit
  ) else $error("Foreign address accepted");
  a_pack_single: assert property (
    rec_valid && !rec.panel && rec.dbits == 4'h2 && rec.sbits == 4'h2 &&
      s.live.wp < 6'(IMG_BYTES) |=>
      s.live.mb[$past(s.live.wp[4:0])][3:0] ==
        {$past(rec.status[1:0]), $past(rec.data[1:0])}
  ) else $error("Two-channel byte packed wrongly");
  a_pack_split: assert property (
    rec_valid && !rec.panel && !rec.last && rec.dbits == 4'h6 &&
      rec.sbits == 4'h6 && s.live.wp < 6'(IMG_BYTES - 1) |=>
      s.live.wp == $past(s.live.wp) + 6'h02
  ) else $error("Wide module not split in two bytes");
  a_hdr_island: assert property (
    s.tx == TX_DIAG && push_v && s.idx == 6'h06 |=> s.hd_v &&
      (s.hd.data == HDR_ISLAND || s.tl.data == HDR_ISLAND)
  ) else $error("Island header wrong");
  a_hdr_module: assert property (
    s.tx == TX_DIAG && push_v && s.idx == 6'h0F |->
      push_b.data == (diag_ext ? HDR_MOD_EXT : HDR_MOD_DEF)
  ) else $error("Module header wrong");
  a_reserved_zero: assert property (
    s.tx == TX_DIAG && push_v && !diag_ext && s.idx >= DIAG_EXT_BASE |->
      push_b.data == 8'h00
  ) else $error("Reserved byte not zero");
  a_diag_last: assert property (
    s.tx == TX_DIAG && push_v && !diag_ext |->
      push_b.last == (s.idx == DIAG_DEF_LEN - 6'h01)
  ) else $error("Default message length not 32");
  a_stat_bit: assert property (
    s.tx == TX_DIAG && push_v && s.idx == 6'h00 |->
      push_b.data[SS1_DIAG] == diag_any &&
      push_b.data[SS1_NOT_READY] == dinfo.not_ready &&
      push_b.data[SS1_CFG_FAULT] == dinfo.cfg_fault
  ) else $error("Station status bits wrong");
  a_out_hold: assert property (
    out_valid && !out_ready |=> out_valid && $stable(out_data)
  ) else $error("Stalled byte lost");
  a_panel_tail: assert property (
    s.tx == TX_IN && push_v && !s.frozen && s.idx == s.live.mlen &&
      s.live.plen != 3'h0 |-> push_b.data == s.live.pb[0]
  ) else $error("Panel bytes not after module bytes");
  a_ident_high: assert property (
    s.tx == TX_DIAG && push_v && s.idx == 6'h04 |->
      push_b.data == IDENT_CODE[15:8]
  ) else $error("Ident high byte wrong");
  a_dev_status: assert property (
    s.tx == TX_DIAG && push_v && s.idx == 6'h0E |->
      push_b.data == dinfo.node_health_word[15:8]
  ) else $error("Device status high byte wrong");
  a_health_bits: assert property (
    s.tx == TX_DIAG && push_v && s.idx == 6'h10 |->
      push_b.data == s.health[7:0]
  ) else $error("Module health byte wrong");
  a_chan_start: assert property (
    s.tx == TX_DIAG && push_v && diag_ext && s.idx == DIAG_EXT_BASE |->
      push_b.data == ch_rec[0][23:16]
  ) else $error("Channel records do not start at byte 20");
  a_ext_length: assert property (
    s.tx == TX_IDLE && diag_req && !in_req && diag_ext |=>
      s.len == DIAG_EXT_BASE + 6'(3 * $past(ch_cnt)) && s.len <= 6'h3E
  ) else $error("Extended message length wrong");
  a_diag_start: assert property (
    s.tx == TX_IDLE && diag_req && !in_req |=> s.tx == TX_DIAG
  ) else $error("Diagnostics request not served");
  a_reset_state: assert property (
    !$past(rstn) |-> !s.frozen && s.od == '0 && s.health == '0 && !s.hd_v
  ) else $error("State not cleared by reset");

  c_freeze: cover property (gc_hit && gc_cmd == GC_FREEZE);
  c_ext_last: cover property (out_valid && out_last && out_diag && diag_ext);
  c_stall_full: cover property (s.tl_v && !out_ready);
  c_panel_sent: cover property (s.tx == TX_IN && push_v &&
    s.idx >= s.live.mlen && !s.frozen);
endmodule

// File: test/fbn_master_model.sv
// Fieldbus master model that consumes the node's byte stream
`timescale 1ns/100ps
module fbn_master_model (
  input wire logic sys_clk,
  input wire logic rstn,
  input wire logic slow,
  input wire logic out_valid,
  input wire logic [7:0] out_data,
  input wire logic out_last,
  input wire logic out_diag,
  output logic out_ready
);
  logic [8:0] got [0:255];
  int n_got;
  int frames;
  logic [1:0] ph;
  // Slow mode stalls three cycles in four so the buffer fills
  assign out_ready = !slow || (ph == 2'h3);
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      ph <= 2'h0;
      n_got <= 0;
      frames <= 0;
    end else begin
      ph <= ph + 2'h1;
      if (out_valid && out_ready) begin
        got[n_got[7:0]] <= {out_diag, out_data};
        n_got <= n_got + 1;
        if (out_last) begin
          frames <= frames + 1;
        end
      end
    end
  end
endmodule

// File: test/fbn_framer_bench.sv
// Self-checking bench of the node framer
`timescale 1ns/100ps
module fbn_framer_bench
  import fbn_pkg::*;
;
  typedef struct packed {
    logic panel;
    logic [15:0] data;
    logic [3:0] dbits;
    logic [7:0] status;
    logic [3:0] sbits;
    logic [1:0] n;
    logic [15:0] e;
  } fbn_row_t;
  // Panel row sits second: its bytes must still come last
  localparam fbn_row_t ROWS [4] = '{
    '{1'b0, 16'h0002, 4'h2, 8'h01, 4'h2, 2'h1, 16'h0600},
    '{1'b1, 16'hA55A, 4'h0, 8'h00, 4'h0, 2'h2, 16'hA55A},
    '{1'b0, 16'h002B, 4'h6, 8'h15, 4'h6, 2'h2, 16'h2B15},
    '{1'b0, 16'h0005, 4'h4, 8'h0A, 4'h4, 2'h1, 16'hA500}};
  logic sys_clk = 1'b0;
  logic rstn, rec_valid, health_valid, gc_valid, od_wr, in_req, diag_req;
  logic diag_ext, slow, out_ready, out_valid, out_last, out_diag;
  logic frozen, dx_started;
  logic [6:0] station_addr, gc_addr;
  fbn_rec_t rec;
  fbn_gc_t gc_cmd;
  fbn_diag_t dinfo;
  logic [31:0] health_in;
  logic [3:0] od_idx, ch_count;
  logic [7:0] od_byte, out_data;
  logic [CH_MAX-1:0][23:0] ch_rec;
  logic [OD_BYTES-1:0][7:0] out_image;
  logic [8:0] eq[$], qa[$];
  int err_count = 0;
  int n_checks = 0;
  int cyc = 0;

  fbn_framer dut (.sys_clk(sys_clk), .rstn(rstn),
    .station_addr(station_addr), .rec_valid(rec_valid), .rec(rec),
    .health_valid(health_valid), .health_in(health_in),
    .gc_valid(gc_valid), .gc_addr(gc_addr), .gc_cmd(gc_cmd),
    .od_wr(od_wr), .od_idx(od_idx), .od_byte(od_byte), .in_req(in_req),
    .diag_req(diag_req), .diag_ext(diag_ext), .ch_count(ch_count),
    .ch_rec(ch_rec), .dinfo(dinfo), .out_ready(out_ready),
    .out_valid(out_valid), .out_data(out_data), .out_last(out_last),
    .out_diag(out_diag), .frozen(frozen), .dx_started(dx_started),
    .out_image(out_image));
  fbn_master_model mdl (.sys_clk(sys_clk), .rstn(rstn), .slow(slow),
    .out_valid(out_valid), .out_data(out_data), .out_last(out_last),
    .out_diag(out_diag), .out_ready(out_ready));

  initial begin
    forever #2.5 sys_clk = ~sys_clk;
  end
  always @(posedge sys_clk) begin
    cyc++;
    if (cyc == 20000) begin
      err_count++;
      close_out();
    end
  end

  task automatic close_out();
    if (err_count == 0 && n_checks > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask
  task automatic chk(string nm, logic [31:0] seen, logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      err_count++;
      $display("unexpected %s: expected %h, seen %h", nm, exp, seen);
    end
  endtask
  task automatic scan_a();
    logic [8:0] pq[$];
    qa = {};
    rec_valid = 1'b1;
    for (int i = 0; i < 4; i++) begin
      rec = '{ROWS[i].panel, i == 3, ROWS[i].data, ROWS[i].dbits,
        ROWS[i].status, ROWS[i].sbits};
      for (int b = 0; b < ROWS[i].n; b++) begin
        if (ROWS[i].panel) pq.push_back({1'b0, ROWS[i].e[15-8*b -: 8]});
        else qa.push_back({1'b0, ROWS[i].e[15-8*b -: 8]});
      end
      @(negedge sys_clk);
    end
    rec_valid = 1'b0;
    qa = {qa, pq};
  endtask
  task automatic gc(logic [6:0] a, fbn_gc_t c);
    gc_addr = a;
    gc_cmd = c;
    gc_valid = 1'b1;
    @(negedge sys_clk);
    gc_valid = 1'b0;
    @(negedge sys_clk);
  endtask
  task automatic xfer(logic dg);
    int n0;
    int f0;
    n0 = mdl.n_got;
    f0 = mdl.frames;
    if (dg) diag_req = 1'b1;
    else in_req = 1'b1;
    @(negedge sys_clk);
    diag_req = 1'b0;
    in_req = 1'b0;
    for (int t = 0; t < 500 && mdl.frames == f0; t++) @(negedge sys_clk);
    chk("length", mdl.n_got - n0, eq.size());
    foreach (eq[i]) chk("byte", mdl.got[n0 + i], eq[i]);
  endtask
  task automatic diag_exp(logic ext, int cnt, logic [31:0] hl);
    int c;
    logic [7:0] h [20];
    c = cnt > CH_MAX ? CH_MAX : cnt;
    h = '{{4'h0, hl != 0 || (ext && c > 0), dinfo.cfg_fault,
      dinfo.not_ready, 1'b0}, dinfo.stat2, dinfo.stat3, dinfo.master_addr,
      IDENT_CODE[15:8], IDENT_CODE[7:0], 8'h09, dinfo.fw_rev[7:0],
      dinfo.fw_rev[15:8], dinfo.node_health_word[7:0],
      dinfo.island_state[7:0], dinfo.island_state[15:8],
      dinfo.global_err[7:0], dinfo.global_err[15:8],
      dinfo.node_health_word[15:8], ext ? 8'h45 : 8'h51,
      hl[7:0], hl[15:8], hl[23:16], hl[31:24]};
    eq = {};
    foreach (h[i]) eq.push_back({1'b1, h[i]});
    for (int i = 0; i < (ext ? 3 * c : 12); i++)
      eq.push_back({1'b1, ext ? ch_rec[i / 3][23 - 8 * (i % 3) -: 8] : 8'h00});
  endtask

  initial begin
    {rec_valid, health_valid, gc_valid, od_wr, in_req, diag_req} = '0;
    {diag_ext, slow, rec, health_in, gc_addr, od_idx, od_byte} = '0;
    gc_cmd = GC_NONE;
    ch_count = 4'h0;
    station_addr = 7'h05;
    dinfo = '{8'h12, 8'h34, 8'h02, 16'hBEEF, 16'hC3A5, 16'h5AA5, 16'h6996,
      1'b1, 1'b0};
    for (int i = 0; i < CH_MAX; i++) ch_rec[i] = {8'(i + 1), 8'h02, 8'(i + 64)};
    rstn = 1'b0;
    repeat (10) @(negedge sys_clk);
    rstn = 1'b1;
    @(negedge sys_clk);
    chk("reset flags", {out_valid, frozen, dx_started}, 3'h0);
    chk("reset image", out_image == '0, 1'b1);
    gc(7'h7F, GC_FREEZE);
    chk("early freeze", frozen, 1'b0);
    scan_a();
    eq = qa;
    xfer(1'b0);
    chk("exchange started", dx_started, 1'b1);
    gc(7'h7F, GC_FREEZE);
    chk("frozen", frozen, 1'b1);
    rec = '{1'b0, 1'b1, 16'h0003, 4'h2, 8'h00, 4'h2};
    rec_valid = 1'b1;
    @(negedge sys_clk);
    rec_valid = 1'b0;
    xfer(1'b0);
    gc(7'h05, GC_FREEZE);
    eq = '{9'h003};
    xfer(1'b0);
    scan_a();
    gc(7'h06, GC_UNFREEZE);
    chk("still frozen", frozen, 1'b1);
    gc(7'h7F, GC_UNFREEZE);
    chk("unfrozen", frozen, 1'b0);
    eq = qa;
    xfer(1'b0);
    od_idx = 4'h3;
    od_byte = 8'h5A;
    od_wr = 1'b1;
    @(negedge sys_clk);
    od_wr = 1'b0;
    chk("output byte", out_image[3], 8'h5A);
    gc(7'h7F, GC_CLEAR);
    chk("cleared", out_image == '0, 1'b1);
    diag_exp(1'b0, 0, 32'h0);
    xfer(1'b1);
    health_in = 32'h80000001;
    health_valid = 1'b1;
    @(negedge sys_clk);
    health_valid = 1'b0;
    slow = 1'b1;
    diag_exp(1'b0, 0, health_in);
    xfer(1'b1);
    diag_ext = 1'b1;
    foreach (ROWS[k]) begin
      ch_count = 4'(k * 5);
      diag_exp(1'b1, k * 5, health_in);
      xfer(1'b1);
    end
    // Mid-run reset must drop freeze, buffer and exchange state
    gc(7'h7F, GC_FREEZE);
    od_wr = 1'b1;
    @(negedge sys_clk);
    od_wr = 1'b0;
    chk("refrozen", {frozen, out_image[3]}, 9'h15A);
    rstn = 1'b0;
    @(negedge sys_clk);
    rstn = 1'b1;
    @(negedge sys_clk);
    chk("rerun flags", {out_valid, frozen, dx_started}, 3'h0);
    chk("rerun image", out_image == '0, 1'b1);
    ch_count = 4'h1;
    diag_exp(1'b1, 1, 32'h0);
    xfer(1'b1);
    close_out();
  end
endmodule
